// ===== rtl/hpt_regs.sv
// Purpose: Trim and link status register bank on AHB-Lite
// Assumes: Link status levels come from another clock domain
// Notes: Zero wait states; response always OKAY
`timescale 1ns/100ps
`include "hpt_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module hpt_regs (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Link status: 0 upstream, 1 port 1, 2 port 2
    input wire hpt_pkg::hpt_link_status_t [2:0] link_status_i,
    // Drive trim to PHY: index 0..2 is port 1..3
    output hpt_pkg::hpt_drive_code_t [2:0] highspeed_drive_trim_o,
    // Squelch trim to PHY: index 0..1 is port 1..2
    output hpt_pkg::hpt_squelch_code_t [1:0] squelch_threshold_trim_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Slot map
    // Slots 0..2 are link status, 3..5 drive trims, 6..7 squelch trims;
    // decode, write mask and read mux all use this numbering

    localparam int NSLOT = 8; // Registers in the bank
    localparam int NSTAT = 3; // Link status slots 0..2
    localparam int NDRV = 3; // Drive trim slots 3..5
    localparam int NSQ = 2; // Squelch trim slots 6..7
    localparam int DRV0 = NSTAT; // First drive slot
    localparam int SQ0 = NSTAT + NDRV; // First squelch slot
    localparam int SYNCW = NSTAT * 7; // Synchronised status bits

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    // A new register needs a case in the decode and a mask in the second

    // Index to one-hot slot select; unmapped gives none
    function automatic logic [NSLOT-1:0] hpt_decode(input logic [29:0] idx);
        logic [NSLOT-1:0] sel;
        sel = '0;
        case (idx)
            `HPT_IDX_UP_LINK_STATUS: sel[0] = 1'b1;
            `HPT_IDX_P1_LINK_STATUS: sel[1] = 1'b1;
            `HPT_IDX_P2_LINK_STATUS: sel[2] = 1'b1;
            `HPT_IDX_P1_DRIVE_TRIM: sel[DRV0] = 1'b1;
            `HPT_IDX_P2_DRIVE_TRIM: sel[DRV0+1] = 1'b1;
            `HPT_IDX_P3_DRIVE_TRIM: sel[DRV0+2] = 1'b1;
            `HPT_IDX_P1_SQUELCH_TRIM: sel[SQ0] = 1'b1;
            `HPT_IDX_P2_SQUELCH_TRIM: sel[SQ0+1] = 1'b1;
            default: sel = '0;
        endcase
        return sel;
    endfunction

    // Writable bits of a slot
    function automatic logic [7:0] hpt_wmask(input int slot);
        logic [7:0] m;
        m = `HPT_STATUS_WMASK; // Status slots take no write
        if (slot >= SQ0)
        begin
            m = `HPT_SQUELCH_WMASK;
        end
        else if (slot >= DRV0)
        begin
            m = `HPT_DRIVE_WMASK;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Bus state and answer registers
    hpt_pkg::hpt_ahb_req_t dp_r; // Pending data phase
    hpt_pkg::hpt_ahb_req_t dp_nxt;
    logic [31:0] hrdata_r; // Read data
    logic [31:0] hrdata_nxt;
    logic hreadyout_r; // Ready toward master
    logic hreadyout_nxt;
    logic hresp_r; // Response, OKAY
    logic hresp_nxt;

    // Datapath between the slots and the bus
    logic [SYNCW-1:0] link_sync; // Status after two flops
    hpt_pkg::hpt_link_status_t [NSTAT-1:0] link_q; // Same, as fields
    logic [7:0] slot_val [NSLOT]; // Current slot contents
    logic [7:0] slot_fwd [NSLOT]; // Contents after pending write
    logic [NSLOT-1:0] wr_en; // Write strobe per slot
    logic [NSLOT-1:0] dp_sel; // Data phase select
    logic [NSLOT-1:0] ap_sel; // Address phase select
    logic [7:0] wr_byte; // Write data lane 0
    logic [7:0] rd_byte; // Read data before register
    logic ap_take; // Address phase accepted

    ////////////////////////////////////////////////////////////////////////////
    // Link status input

    // Limitation: each bit is synchronised on its own, so a status that
    // changes while it is read may show old and new bits mixed in that
    // one read; the link layer changes it rarely, so read it twice
    // Status crosses from the link clock; two flops before use
    hpt_sync #(
        .WIDTH(SYNCW)
    ) u_link_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .d_i(link_status_i),
        .q_o(link_sync)
    );

    assign link_q = link_sync;

    // Status byte: state high nibble, bit 3 zero, sub-state low
    // These bytes have no storage, so a write can never reach them
    genvar gs;
    generate
        for (gs = 0; gs < NSTAT; gs++)
        begin : g_status
            always_comb
            begin
                slot_val[gs] = 8'h00; // Reserved bit 3 reads zero
                slot_val[gs][`HPT_LINK_STATE_MSB:`HPT_LINK_STATE_LSB] =
                    link_q[gs].state;
                slot_val[gs][`HPT_LINK_SUB_MSB:`HPT_LINK_SUB_LSB] =
                    link_q[gs].sub_state;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Trim storage

    // Trims leave reset at the nominal code, so the PHY runs at its
    // default drive and squelch until software tunes it
    // Drive trim: all eight bits kept, code in 2:0
    genvar gd;
    generate
        for (gd = 0; gd < NDRV; gd++)
        begin : g_drive
            hpt_trim_reg #(
                .RST_VAL(`HPT_DRIVE_RST),
                .WMASK(`HPT_DRIVE_WMASK)
            ) u_reg (
                .clk_sys_i(clk_sys_i),
                .nrst_i(nrst_i),
                .wr_en_i(wr_en[DRV0+gd]),
                .wdata_i(wr_byte),
                .q_o(slot_val[DRV0+gd])
            );
            // Code drives the PHY current level
            assign highspeed_drive_trim_o[gd] = hpt_pkg::hpt_drive_code_t'(
                slot_val[DRV0+gd][`HPT_TRIM_MSB:`HPT_TRIM_LSB]);
        end
    endgenerate

    // Squelch trim: code in 2:0, upper bits fixed at zero
    genvar gq;
    generate
        for (gq = 0; gq < NSQ; gq++)
        begin : g_squelch
            hpt_trim_reg #(
                .RST_VAL(`HPT_SQUELCH_RST),
                .WMASK(`HPT_SQUELCH_WMASK)
            ) u_reg (
                .clk_sys_i(clk_sys_i),
                .nrst_i(nrst_i),
                .wr_en_i(wr_en[SQ0+gq]),
                .wdata_i(wr_byte),
                .q_o(slot_val[SQ0+gq])
            );
            // Code sets the PHY squelch trip point
            assign squelch_threshold_trim_o[gq] = hpt_pkg::hpt_squelch_code_t'(
                slot_val[SQ0+gq][`HPT_TRIM_MSB:`HPT_TRIM_LSB]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Write path

    // No wait state: the byte is merged at the edge that ends the data
    // phase, and the trim output moves in the cycle after it
    // Write lands at the end of the data phase, lane 0 only
    always_comb
    begin
        dp_sel = hpt_decode(dp_r.idx);
        wr_byte = hwdata_i[7:0];
        wr_en = '0;
        if (dp_r.valid && dp_r.write && dp_r.lane0)
        begin
            wr_en = dp_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Without forwarding, a read taken in the data phase of a write
    // would return the byte from before that write
    // Forward a pending write so a read right behind it is fresh;
    // status slots have an empty mask, so writes to them are lost
    always_comb
    begin
        for (int i = 0; i < NSLOT; i++)
        begin
            slot_fwd[i] = slot_val[i];
            if (wr_en[i])
            begin
                slot_fwd[i] = (slot_val[i] & ~hpt_wmask(i)) |
                    (wr_byte & hpt_wmask(i));
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        ap_take = hsel_i && hready_i && htrans_i[1];
        ap_sel = hpt_decode(haddr_i[31:2]);
        rd_byte = 8'h00;
        for (int i = 0; i < NSLOT; i++)
        begin
            if (ap_sel[i])
            begin
                rd_byte = slot_fwd[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    // Every transfer is answered at once with OKAY; hready_i only
    // qualifies new address phases, as this slave never holds a data
    // phase open and so is never the one that stalls the bus
    // Next values of the address capture and answer
    always_comb
    begin
        dp_nxt = '0;
        hrdata_nxt = 32'h00000000;
        hreadyout_nxt = 1'b1; // Never stalls
        hresp_nxt = 1'b0; // Always OKAY
        if (ap_take)
        begin
            dp_nxt.valid = 1'b1;
            dp_nxt.write = hwrite_i;
            dp_nxt.lane0 = (haddr_i[1:0] == 2'b00);
            dp_nxt.idx = haddr_i[31:2];
            if (!hwrite_i)
            begin
                // Narrow data in low bits, rest zero
                hrdata_nxt = {24'h000000, rd_byte};
            end
        end
    end

    // Slave registers, synchronous reset
    // Reset leaves the bus ready, OKAY, with no data phase pending
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            dp_r <= '0;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
        else
        begin
            dp_r <= dp_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= hresp_nxt;
        end
    end

    // Bus outputs straight from flops
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o = hresp_r;

    // Whole-word transfers are expected from the master; the low byte
    // lane is all that any register uses
    // hsize_i is accepted for any width; only lane 0 carries data
    logic hsize_unused;
    assign hsize_unused = ^hsize_i;

endmodule

// ===== rtl/hpt_cfg.svh
// Purpose: Offsets, field positions, write masks and reset values
// Assumes: Offsets are register indices; byte address = 4 * index
// Notes: Definitions only
`ifndef HPT_CFG_SVH
`define HPT_CFG_SVH

// Register indices (haddr[31:2])
`define HPT_IDX_UP_LINK_STATUS 30'h000061c0
`define HPT_IDX_P1_DRIVE_TRIM 30'h000064ca
`define HPT_IDX_P1_SQUELCH_TRIM 30'h000064cc
`define HPT_IDX_P1_LINK_STATUS 30'h000065c0
`define HPT_IDX_P2_DRIVE_TRIM 30'h000068ca
`define HPT_IDX_P2_SQUELCH_TRIM 30'h000068cc
`define HPT_IDX_P2_LINK_STATUS 30'h000069c0
`define HPT_IDX_P3_DRIVE_TRIM 30'h00006cca

// Field positions
`define HPT_LINK_STATE_MSB 7
`define HPT_LINK_STATE_LSB 4
`define HPT_LINK_RSVD_BIT 3
`define HPT_LINK_SUB_MSB 2
`define HPT_LINK_SUB_LSB 0
`define HPT_TRIM_MSB 2
`define HPT_TRIM_LSB 0

// Write masks: set bits are writable storage
`define HPT_STATUS_WMASK 8'h00
`define HPT_DRIVE_WMASK 8'hff
`define HPT_SQUELCH_WMASK 8'h07

// Reset values
`define HPT_DRIVE_RST 8'h00
`define HPT_SQUELCH_RST 8'h00

`endif

// ===== rtl/hpt_pkg.sv
// Purpose: Types shared by the trim and link status register bank
// Assumes: Nothing
// Notes: Constants live in hpt_cfg.svh
package hpt_pkg;

    // Link state and sub-state from the link layer
    typedef struct packed {
        logic [3:0] state;
        logic [2:0] sub_state;
    } hpt_link_status_t;

    // High-speed output current levels
    typedef enum logic [2:0] {
        HPT_DRV_NOMINAL = 3'h0,
        HPT_DRV_MINUS5 = 3'h1,
        HPT_DRV_PLUS10 = 3'h2,
        HPT_DRV_PLUS5 = 3'h3,
        HPT_DRV_PLUS20 = 3'h4,
        HPT_DRV_PLUS15 = 3'h5,
        HPT_DRV_PLUS30 = 3'h6,
        HPT_DRV_PLUS25 = 3'h7
    } hpt_drive_code_t;

    // Squelch trip points around a nominal 100 mV
    typedef enum logic [2:0] {
        HPT_SQ_NOMINAL_100MV = 3'h0,
        HPT_SQ_DOWN_12P5MV = 3'h1,
        HPT_SQ_DOWN_25MV = 3'h2,
        HPT_SQ_DOWN_37P5MV = 3'h3,
        HPT_SQ_DOWN_50MV = 3'h4,
        HPT_SQ_DOWN_62P5MV = 3'h5,
        HPT_SQ_UP_25MV = 3'h6,
        HPT_SQ_UP_12P5MV = 3'h7
    } hpt_squelch_code_t;

    // Captured bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic lane0;
        logic [29:0] idx;
    } hpt_ahb_req_t;

endpackage

// ===== rtl/hpt_sync.sv
// Purpose: Two-stage synchroniser for a bundle of levels
// Assumes: Bits are quasi-static levels
// Notes: First stage feeds only the second
`timescale 1ns/100ps
module hpt_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Levels in and out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r; // First stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r; // Second stage
    logic [WIDTH-1:0] sync_nxt;

    // Next values: shift one stage
    always_comb
    begin
        meta_nxt = d_i;
        sync_nxt = meta_r;
    end

    // Stages, cleared by reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_o = sync_r;

endmodule

// ===== rtl/hpt_trim_reg.sv
// Purpose: One byte register with a per-bit write mask
// Assumes: Write strobe and data on the same clock
// Notes: Masked-off bits keep their reset value
`timescale 1ns/100ps
module hpt_trim_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hff
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    // Stored value
    output logic [7:0] q_o
);

    logic [7:0] val_r; // Stored byte
    logic [7:0] val_nxt;

    // Merge writable bits only
    always_comb
    begin
        val_nxt = val_r;
        if (wr_en_i)
        begin
            val_nxt = (val_r & ~WMASK) | (wdata_i & WMASK);
        end
    end

    // Register
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            val_r <= RST_VAL;
        end
        else
        begin
            val_r <= val_nxt;
        end
    end

    assign q_o = val_r;

endmodule

// ===== verif/hpt_regs_monitor.sv
// Purpose: Concurrent checks on the trim and link status bank ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every hpt_regs instance below the module
`timescale 1ns/100ps
`include "hpt_cfg.svh"

module hpt_regs_monitor (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Bus side
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // PHY side
    input wire hpt_pkg::hpt_link_status_t [2:0] link_status_i,
    input wire hpt_pkg::hpt_drive_code_t [2:0] highspeed_drive_trim_o,
    input wire hpt_pkg::hpt_squelch_code_t [1:0] squelch_threshold_trim_o
);

////////////////////////////////////////////////////////////////////////////////
    // Decode of the address phase taken at each edge
    logic take;
    logic rd;
    logic wr;
    logic [29:0] idx;
    assign take = hsel_i & hready_i & htrans_i[1];
    assign rd = take & ~hwrite_i;
    assign wr = take & hwrite_i & (haddr_i[1:0] == 2'b00);
    assign idx = haddr_i[31:2];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

////////////////////////////////////////////////////////////////////////////////
    // Status read of a link input held steady long enough to pass the sync
    property p_link(int k, logic [29:0] ri);
        $stable(link_status_i[k]) [*4] ##0 (rd && idx == ri) |=> hrdata_o ==
            {24'h0, $past(link_status_i[k].state), 1'b0, $past(link_status_i[k].sub_state)};
    endproperty

    a_up_link: assert property (p_link(0, `HPT_IDX_UP_LINK_STATUS))
        else $error("upstream status read wrong");
    a_p1_link: assert property (p_link(1, `HPT_IDX_P1_LINK_STATUS))
        else $error("port 1 status read wrong");
    a_p2_link: assert property (p_link(2, `HPT_IDX_P2_LINK_STATUS))
        else $error("port 2 status read wrong");
    a_status_rsvd: assert property (rd && (idx == `HPT_IDX_UP_LINK_STATUS ||
        idx == `HPT_IDX_P1_LINK_STATUS || idx == `HPT_IDX_P2_LINK_STATUS) |=> !hrdata_o[3])
        else $error("status reserved bit not zero");
    a_squelch_rsvd: assert property (rd && (idx == `HPT_IDX_P1_SQUELCH_TRIM ||
        idx == `HPT_IDX_P2_SQUELCH_TRIM) |=> hrdata_o[7:3] == 5'h00)
        else $error("squelch reserved bits not zero");
    a_drive_write: assert property (wr && idx == `HPT_IDX_P1_DRIVE_TRIM |=>
        ##1 highspeed_drive_trim_o[0] == $past(hwdata_i[2:0]))
        else $error("drive trim not taken from write");
    a_squelch_write: assert property (wr && idx == `HPT_IDX_P1_SQUELCH_TRIM |=>
        ##1 squelch_threshold_trim_o[0] == $past(hwdata_i[2:0]))
        else $error("squelch trim not taken from write");
    a_trim_cause: assert property ($changed({highspeed_drive_trim_o,
        squelch_threshold_trim_o}) |-> $past(wr, 2))
        else $error("trim changed without a write");
    a_read_idle: assert property (!$past(rd) |-> hrdata_o == 32'h0)
        else $error("read data outside data phase");

    // Main scenarios
    c_drive_wr: cover property (wr && idx == `HPT_IDX_P1_DRIVE_TRIM);
    c_status_rd: cover property (rd && idx == `HPT_IDX_P2_LINK_STATUS);
    c_wr_then_rd: cover property (wr ##1 rd);
endmodule

bind hpt_regs hpt_regs_monitor u_mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .link_status_i(link_status_i),
    .highspeed_drive_trim_o(highspeed_drive_trim_o),
    .squelch_threshold_trim_o(squelch_threshold_trim_o));

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the trim and link status bank
// Assumes: Single AHB-Lite master, one slave, 50 MHz clock
// Notes: Byte model of the registers predicts every read and trim
`timescale 1ns/100ps
`include "hpt_cfg.svh"

module testbench;
    // Design inputs and outputs
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    hpt_pkg::hpt_link_status_t [2:0] link_status_i = '0;
    hpt_pkg::hpt_drive_code_t [2:0] highspeed_drive_trim_o;
    hpt_pkg::hpt_squelch_code_t [1:0] squelch_threshold_trim_o;
    // Bench state
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] model [9];
    logic [31:0] rdata;
    // Register table: kind 0 status, 1 drive, 2 squelch, 3 unmapped
    localparam logic [29:0] IDX [9] = '{`HPT_IDX_UP_LINK_STATUS, `HPT_IDX_P1_DRIVE_TRIM,
        `HPT_IDX_P1_SQUELCH_TRIM, `HPT_IDX_P1_LINK_STATUS, `HPT_IDX_P2_DRIVE_TRIM,
        `HPT_IDX_P2_SQUELCH_TRIM, `HPT_IDX_P2_LINK_STATUS, `HPT_IDX_P3_DRIVE_TRIM,
        30'h000064cb};
    localparam int KIND [9] = '{0, 1, 2, 0, 1, 2, 0, 1, 3};
    localparam int PORT [9] = '{0, 0, 0, 1, 1, 1, 2, 2, 0};
    localparam int DRV_REG [3] = '{1, 4, 7};
    localparam int SQ_REG [2] = '{2, 5};

    // 50 MHz clock
    always #10 clk_sys_i = ~clk_sys_i;

    hpt_regs u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .link_status_i(link_status_i),
        .highspeed_drive_trim_o(highspeed_drive_trim_o),
        .squelch_threshold_trim_o(squelch_threshold_trim_o));

////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Hang guard
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Single AHB transfer; entered just after a rising edge
    task automatic xfer(input logic w, input int r, input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {IDX[r], 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rdata = hrdata_o;
        check(32'(hresp_o), 32'h0);
    endtask

    // Model of a read
    function automatic logic [31:0] expect_rd(int r);
        case (KIND[r])
            0: return {24'h0, link_status_i[PORT[r]].state, 1'b0,
                link_status_i[PORT[r]].sub_state};
            1, 2: return {24'h0, model[r]};
            default: return 32'h0;
        endcase
    endfunction

    // Trim outputs against the model
    task automatic chk_outs();
        for (int p = 0; p < 3; p++)
            check(32'(highspeed_drive_trim_o[p]), 32'(model[DRV_REG[p]][2:0]));
        for (int p = 0; p < 2; p++)
            check(32'(squelch_threshold_trim_o[p]), 32'(model[SQ_REG[p]][2:0]));
    endtask

    // Access with prediction; writes check outputs once settled
    task automatic access(input logic w, input int r, input logic [31:0] wd);
        logic [31:0] e;
        e = expect_rd(r);
        xfer(w, r, wd);
        if (w)
        begin
            if (KIND[r] == 1)
                model[r] = wd[7:0];
            else if (KIND[r] == 2)
                model[r] = wd[7:0] & 8'h07;
            @(negedge clk_sys_i);
            chk_outs();
            @(posedge clk_sys_i);
        end
        else
            check(rdata, e);
    endtask

    // Write then read of one register back to back; the read sees the write
    task automatic wr_rd(input int r, input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {IDX[r], 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= 1'b1;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        hwrite_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rdata = hrdata_o;
        if (KIND[r] == 1)
            model[r] = wd[7:0];
        else if (KIND[r] == 2)
            model[r] = wd[7:0] & 8'h07;
        check(rdata, expect_rd(r));
        chk_outs();
    endtask

    // Reset pulse, then wait out the status sync
    task automatic do_reset(input int n);
        nrst_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        for (int i = 0; i < 9; i++)
            model[i] = 8'h00;
    endtask

////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(22));
        link_status_i <= 21'($urandom);
        do_reset(16);
        chk_outs();
        for (int r = 0; r < 9; r++)
            access(1'b0, r, 32'h0);
        // Every code on every trim, upper bits random
        for (int c = 0; c < 8; c++)
            for (int r = 0; r < 9; r++)
                if (KIND[r] == 1 || KIND[r] == 2)
                begin
                    access(1'b1, r, {29'($urandom), 3'(c)});
                    access(1'b0, r, 32'h0);
                end
        // Write then read at once, so the read takes the forwarded byte
        for (int i = 0; i < 24; i++)
            wr_rd(int'($urandom_range(8)), $urandom);
        // Random mix, status and unmapped writes included
        for (int i = 0; i < 80; i++)
        begin
            access(1'($urandom_range(1)), int'($urandom_range(8)), $urandom);
            if ($urandom_range(3) == 0)
            begin
                link_status_i <= 21'($urandom);
                repeat (4) @(posedge clk_sys_i);
            end
        end
        // Reset in mid-run clears the trims
        do_reset(2);
        chk_outs();
        for (int r = 0; r < 9; r++)
            access(1'b0, r, 32'h0);
        print_verdict();
    end
endmodule
